// File: drive_plant_model.sv
// far-side model: motor speed feedback and the second forced-stop input.
// assumes the bench raises stopReq to ask for a stop; clk/rst as the sequencer.
// one drive on a converter of its own, so no multi-connection setting applies
`timescale 1ns/1ps
module drive_plant_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        stopReq,
    input  wire logic [15:0] speedCmdOut,
    input  wire logic        powerStageOn,
    output logic      [15:0] speedFeedback,
    output logic             forcedStopIn2
);
    // motor follows the command one cycle late while powered; brake halts it at once,
    // which is kinder than a real axis but keeps the run short
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            speedFeedback <= 16'h0000;
            forcedStopIn2 <= 1'b1;
        end else begin
            speedFeedback <= powerStageOn ? speedCmdOut : 16'h0000;
            forcedStopIn2 <= !stopReq; // dropped first, only on request
        end
    end
endmodule

// File: forced_stop_decel_sequencer.sv
// forced stop deceleration sequencer: ramps the speed command to zero on a stop
// request, then shuts off the power stage and engages the dynamic brake.
// assumes pins are asynchronous; network and controller commands arrive as
// same-clock levels; speed feedback is an unsigned magnitude on this clock.
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module forced_stop_decel_sequencer (
    input  wire logic        clk,
    input  wire logic        rst,
    // avalon-mm slave
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic             irq,
    // external pins (asynchronous, active high means closed/ok)
    input  wire logic        forcedStopIn1,
    input  wire logic        forcedStopIn2,
    input  wire logic        safeTorqueOffInput,
    // same-clock system inputs
    input  wire logic        quickStopCmd,
    input  wire logic        emergencyStopCmd,
    input  wire logic        commLost,
    input  wire logic        torqueMode,
    input  wire logic        alarmRampable,
    input  wire logic        alarmDynBrake,
    input  wire logic [15:0] speedFeedback,
    input  wire logic [15:0] speedCmdIn,
    // to the power stage
    output logic      [15:0] speedCmdOut,
    output logic             powerStageOn,
    output logic             dynamicBrakeOn,
    output logic             zeroSpeedDetect,
    output logic      [11:0] warningCode
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pinMeta_r;
    logic [2:0] pinSync_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinMeta_r <= 3'h7;
            pinSync_r <= 3'h7;
        end else begin
            pinMeta_r <= {safeTorqueOffInput, forcedStopIn2, forcedStopIn1};
            pinSync_r <= pinMeta_r;
        end
    end
    wire stop1Ok = pinSync_r[0];
    wire stop2Ok = pinSync_r[1];
    wire torqueOffOk = pinSync_r[2];

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [3:0]          funcSel_r;
    logic [15:0]         ratedSpeed_r;
    logic [15:0]         zeroLevel_r;
    logic [15:0]         decelMs_r;
    logic [fsd_pkg::EVT_W-1:0] evtStat_r;
    logic [fsd_pkg::EVT_W-1:0] evtMask_r;
    fsd_pkg::state_type  state_r;

    wire enabled = (funcSel_r == fsd_pkg::SEL_ENABLED);
    wire wrStrobe = write & ~waitrequest;
    wire hitCtrl  = (address == {1'b0, fsd_pkg::OFF_CTRL});
    wire hitZero  = (address == {1'b0, fsd_pkg::OFF_ZERO});
    wire hitDecel = (address == {1'b0, fsd_pkg::OFF_DECEL});
    wire hitStat  = (address == {1'b0, fsd_pkg::OFF_STATUS});
    wire hitIstat = (address == fsd_pkg::OFF_ISTAT);
    wire hitImask = (address == fsd_pkg::OFF_IMASK);
    wire [3:0] selWr = writedata[fsd_pkg::SEL_LSB +: fsd_pkg::SEL_W];
    wire selLegal = (selWr == fsd_pkg::SEL_DISABLED) || (selWr == fsd_pkg::SEL_ENABLED);

    // read mux, unmapped reads give zero
    logic [31:0] rdMux;
    always_comb begin
        if (hitCtrl)
            rdMux = {ratedSpeed_r, 12'h000, funcSel_r};
        else if (hitZero)
            rdMux = {16'h0000, zeroLevel_r};
        else if (hitDecel)
            rdMux = {16'h0000, decelMs_r};
        else if (hitStat)
            rdMux = {26'h0, zeroSpeedDetect, dynamicBrakeOn, powerStageOn,
                     torqueOffOk, state_r};
        else if (hitIstat)
            rdMux = {28'h0, evtStat_r};
        else if (hitImask)
            rdMux = {28'h0, evtMask_r};
        else
            rdMux = 32'h0;
    end

    // ------------------------------------------------------------
    // bus handshake: waitrequest drops for one cycle per access
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0;
        end else begin
            waitrequest <= ~((read | write) & waitrequest);
            if (read & waitrequest)
                readdata <= rdMux;
        end
    end

    // config writes; illegal selections are ignored and flagged
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            funcSel_r    <= fsd_pkg::SEL_RST;
            ratedSpeed_r <= fsd_pkg::RATED_RST;
            zeroLevel_r  <= fsd_pkg::ZERO_RST;
            decelMs_r    <= fsd_pkg::DECEL_MS_RST;
            evtMask_r    <= '0;
        end else if (wrStrobe) begin
            if (hitCtrl && byteenable[0] && selLegal)
                funcSel_r <= selWr;
            if (hitCtrl && (&byteenable[3:2]))
                ratedSpeed_r <= writedata[31:16];
            if (hitZero && (&byteenable[1:0]))
                zeroLevel_r <= writedata[15:0];
            if (hitDecel && (&byteenable[1:0]))
                decelMs_r <= writedata[15:0];
            if (hitImask && byteenable[0])
                evtMask_r <= writedata[fsd_pkg::EVT_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // stop request decode
    // ------------------------------------------------------------
    // a ramp needs the function enabled and a non-torque mode
    wire rampAllowed = enabled & ~torqueMode;
    wire rampReq = ~stop2Ok
                 | quickStopCmd
                 | emergencyStopCmd
                 | commLost
                 | alarmRampable;
    // direct brake: hard alarms, torque off, first input or any alarm when disabled
    wire brakeReq = alarmDynBrake
                  | ~torqueOffOk
                  | (~enabled & (~stop1Ok | alarmRampable | commLost))
                  | (enabled & torqueMode & rampReq);

    // ------------------------------------------------------------
    // ramp generator: per-tick step = rated * tick / decel time
    // ------------------------------------------------------------
    logic [16:0] tickCnt_r;
    logic [31:0] rampAcc_r;  // 16.16 fixed point speed command
    wire tickEn = (tickCnt_r == 17'(fsd_pkg::TICK_CYCLES - 1));
    wire [15:0] decelSafe = (decelMs_r == 16'h0) ? 16'h0001 : decelMs_r;
    // ticks from rated speed to zero; the step truncates, so the ramp runs a hair long
    wire [31:0] decelTicks = {16'h0000, decelSafe} * 32'(fsd_pkg::TICKS_PER_MS);
    wire [31:0] stepSize = {ratedSpeed_r, 16'h0000} / decelTicks;
    wire rampDone = (rampAcc_r == 32'h0);
    wire belowZero = (speedFeedback < zeroLevel_r);

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            tickCnt_r <= '0;
        else
            tickCnt_r <= tickEn ? 17'h0 : tickCnt_r + 17'h1;
    end

    // state machine
    fsd_pkg::state_type state_nxt;
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            fsd_pkg::ST_RUN: begin
                if (brakeReq)
                    state_nxt = fsd_pkg::ST_BRAKE;
                else if (rampAllowed & rampReq)
                    state_nxt = fsd_pkg::ST_RAMP;
            end
            fsd_pkg::ST_RAMP: begin
                if (brakeReq)
                    state_nxt = fsd_pkg::ST_BRAKE;
                else if (rampDone & belowZero)
                    state_nxt = fsd_pkg::ST_BRAKE;
            end
            default: begin
                // leave brake only once all stop causes have cleared
                if (~brakeReq & ~rampReq & belowZero)
                    state_nxt = fsd_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            state_r <= fsd_pkg::ST_BRAKE;
        else
            state_r <= state_nxt;
    end

    // ramp accumulator: load from the live command, step down on each tick
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            rampAcc_r <= 32'h0;
        else if (state_r != fsd_pkg::ST_RAMP)
            rampAcc_r <= {speedCmdIn, 16'h0000};
        else if (tickEn)
            rampAcc_r <= (rampAcc_r > stepSize) ? rampAcc_r - stepSize : 32'h0;
    end

    // ------------------------------------------------------------
    // outputs and interrupt events
    // ------------------------------------------------------------
    wire [fsd_pkg::EVT_W-1:0] evtNow = {
        wrStrobe & hitCtrl & byteenable[0] & ~selLegal,
        (state_r == fsd_pkg::ST_RAMP) & (state_nxt == fsd_pkg::ST_BRAKE) & brakeReq,
        (state_r == fsd_pkg::ST_RAMP) & (state_nxt == fsd_pkg::ST_BRAKE) & ~brakeReq,
        (state_r != fsd_pkg::ST_RAMP) & (state_nxt == fsd_pkg::ST_RAMP)};
    wire [fsd_pkg::EVT_W-1:0] evtClr =
        (wrStrobe & hitIstat & byteenable[0]) ? writedata[fsd_pkg::EVT_W-1:0] : '0;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            speedCmdOut     <= 16'h0;
            powerStageOn    <= 1'b0;
            dynamicBrakeOn  <= 1'b1;
            zeroSpeedDetect <= 1'b0;
            warningCode     <= 12'h0;
            evtStat_r       <= '0;
            irq             <= 1'b0;
        end else begin
            speedCmdOut <= (state_nxt == fsd_pkg::ST_RAMP) ? rampAcc_r[31:16]
                         : (state_nxt == fsd_pkg::ST_RUN) ? speedCmdIn : 16'h0;
            powerStageOn    <= (state_nxt != fsd_pkg::ST_BRAKE);
            dynamicBrakeOn  <= (state_nxt == fsd_pkg::ST_BRAKE);
            zeroSpeedDetect <= belowZero;
            warningCode     <= (state_nxt == fsd_pkg::ST_RAMP) ? fsd_pkg::WARN_CODE
                                                               : 12'h0;
            // set wins over clear
            evtStat_r <= (evtStat_r & ~evtClr) | evtNow;
            irq       <= |(((evtStat_r & ~evtClr) | evtNow) & evtMask_r);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_warn_ramp;
        @(posedge clk) disable iff (rst)
        (state_r == fsd_pkg::ST_RAMP) |-> (warningCode == fsd_pkg::WARN_CODE);
    endproperty
    a_warn_ramp: assert property (p_warn_ramp) else $error("warning missing in ramp");

    property p_torque_off_brake;
        @(posedge clk) disable iff (rst)
        (state_r == fsd_pkg::ST_RAMP) && !torqueOffOk |=> dynamicBrakeOn && !powerStageOn;
    endproperty
    a_torque_off_brake: assert property (p_torque_off_brake) else $error("no brake on torque off");

    property p_alarm_brake;
        @(posedge clk) disable iff (rst)
        alarmDynBrake |=> (state_r == fsd_pkg::ST_BRAKE);
    endproperty
    a_alarm_brake: assert property (p_alarm_brake) else $error("alarm did not brake");

    property p_torque_noramp;
        @(posedge clk) disable iff (rst)
        torqueMode && (state_r == fsd_pkg::ST_RUN) |=> (state_r != fsd_pkg::ST_RAMP);
    endproperty
    a_torque_noramp: assert property (p_torque_noramp) else $error("ramp in torque mode");

    property p_stop2_ramp;
        @(posedge clk) disable iff (rst)
        (state_r == fsd_pkg::ST_RUN) && !brakeReq && rampAllowed && !stop2Ok
        |=> (state_r == fsd_pkg::ST_RAMP);
    endproperty
    a_stop2_ramp: assert property (p_stop2_ramp) else $error("no ramp on stop input");

    property p_disabled_noramp;
        @(posedge clk) disable iff (rst)
        !enabled |=> (state_r != fsd_pkg::ST_RAMP) || $past(state_r == fsd_pkg::ST_RAMP);
    endproperty
    a_disabled_noramp: assert property (p_disabled_noramp) else $error("ramp when off");

    property p_ramp_falls;
        @(posedge clk) disable iff (rst)
        (state_r == fsd_pkg::ST_RAMP) && $past(state_r == fsd_pkg::ST_RAMP)
        |-> rampAcc_r <= $past(rampAcc_r);
    endproperty
    a_ramp_falls: assert property (p_ramp_falls) else $error("ramp rose");

    property p_done_brake;
        @(posedge clk) disable iff (rst)
        (state_r == fsd_pkg::ST_RAMP) && rampDone && belowZero
        |=> (state_r == fsd_pkg::ST_BRAKE) && dynamicBrakeOn && !powerStageOn;
    endproperty
    a_done_brake: assert property (p_done_brake) else $error("no brake after ramp");

    property p_sel_legal;
        @(posedge clk) disable iff (rst)
        wrStrobe && hitCtrl && byteenable[0] && !selLegal |=> $stable(funcSel_r);
    endproperty
    a_sel_legal: assert property (p_sel_legal) else $error("illegal select");

    c_ramp_start: cover property (@(posedge clk) disable iff (rst)
        (state_r == fsd_pkg::ST_RUN) ##1 (state_r == fsd_pkg::ST_RAMP));
    c_ramp_done: cover property (@(posedge clk) disable iff (rst)
        (state_r == fsd_pkg::ST_RAMP) && rampDone ##1 (state_r == fsd_pkg::ST_BRAKE));
    c_ramp_abort: cover property (@(posedge clk) disable iff (rst)
        (state_r == fsd_pkg::ST_RAMP) && !torqueOffOk);

endmodule

// File: forced_stop_decel_sequencer_bench.sv
// self-checking bench for the forced stop deceleration sequencer.
// assumes the 10 us control tick, so the whole run stays near 50k cycles.
`timescale 1ns/1ps
module forced_stop_decel_sequencer_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  address = 5'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h00000000;
    logic [31:0] readdata;
    logic [31:0] rd;
    logic        waitrequest, irq, powerStageOn, dynamicBrakeOn, zeroSpeedDetect;
    logic        forcedStopIn1 = 1'b1;
    logic        forcedStopIn2;
    logic        safeTorqueOffInput = 1'b1;
    logic        stopReq = 1'b0;
    logic        quickStopCmd = 1'b0, emergencyStopCmd = 1'b0, commLost = 1'b0;
    logic        torqueMode = 1'b0, alarmRampable = 1'b0, alarmDynBrake = 1'b0;
    logic [15:0] speedFeedback, speedCmdOut;
    logic [15:0] speedCmdIn = 16'h03e8;
    logic [11:0] warningCode;
    int          badCount = 0;
    int          checks = 0;

    always #4 clk = ~clk;

    forced_stop_decel_sequencer dut (
        .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
        .waitrequest(waitrequest), .irq(irq), .forcedStopIn1(forcedStopIn1),
        .forcedStopIn2(forcedStopIn2), .safeTorqueOffInput(safeTorqueOffInput),
        .quickStopCmd(quickStopCmd), .emergencyStopCmd(emergencyStopCmd),
        .commLost(commLost), .torqueMode(torqueMode), .alarmRampable(alarmRampable),
        .alarmDynBrake(alarmDynBrake), .speedFeedback(speedFeedback),
        .speedCmdIn(speedCmdIn), .speedCmdOut(speedCmdOut), .powerStageOn(powerStageOn),
        .dynamicBrakeOn(dynamicBrakeOn), .zeroSpeedDetect(zeroSpeedDetect),
        .warningCode(warningCode));

    drive_plant_model plant (
        .clk(clk), .rst(rst), .stopReq(stopReq), .speedCmdOut(speedCmdOut),
        .powerStageOn(powerStageOn), .speedFeedback(speedFeedback),
        .forcedStopIn2(forcedStopIn2));

    // ------------------------------------------------------------
    // compare and bus tasks
    // ------------------------------------------------------------
    task automatic note(input bit ok, input string what);
        checks++;
        if (!ok) begin
            badCount++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask
    task automatic check_read(input logic [31:0] g, input logic [31:0] e);
        note(g === e, $sformatf("register %h want %h", g, e));
    endtask
    task automatic check_word(input logic [15:0] g, input logic [15:0] e);
        note(g === e, $sformatf("word %h want %h", g, e));
    endtask
    task automatic check_flag(input logic g, input logic e);
        note(g === e, $sformatf("flag %b want %b", g, e));
    endtask

    // avalon access: request held until waitrequest is sampled low, then released
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (waitrequest === 1'b0) break;
        end
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
        if (n == 20) note(1'b0, "no bus answer");
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h00000000);
        check_read(rd, e);
    endtask

    // outputs lag stop pins by at most 4 cycles, so 5 is enough
    task automatic settle;
        repeat (5) @(posedge clk);
    endtask
    task automatic wait_power(input logic v, input int lim);
        for (int n = 0; n < lim && powerStageOn !== v; n++) @(posedge clk);
    endtask
    task automatic recover;
        wait_power(1'b1, 60);
        check_flag(powerStageOn, 1'b1);
    endtask

    task automatic completeRun;
        $display("checks %0d mismatches %0d", checks, badCount);
        if (badCount == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // watchdog: about twice the expected run of 50k cycles
    initial begin
        #800000;
        note(1'b0, "watchdog expired");
        completeRun();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        recover();
        rdchk(5'h00, 32'h0bb80002);
        rdchk(5'h04, 32'h00000032);
        rdchk(5'h08, 32'h00000064);
        rdchk(5'h18, 32'h00000000);
        check_word(speedCmdOut, speedCmdIn);
        // slow ramp from rated speed: 3000 over 100 ms is 0.3 per 10 us tick, so 2999 first
        speedCmdIn <= 16'h0bb8;
        settle();
        stopReq <= 1'b1;
        settle();
        check_word({4'h0, warningCode}, {4'h0, fsd_pkg::WARN_CODE});
        check_flag(powerStageOn, 1'b1);
        check_flag(zeroSpeedDetect, 1'b0);
        for (int n = 0; n < 2000 && speedCmdOut === 16'h0bb8; n++) @(posedge clk);
        check_word(speedCmdOut, 16'h0bb7);
        safeTorqueOffInput <= 1'b0;
        settle();
        check_flag(dynamicBrakeOn, 1'b1);
        check_flag(powerStageOn, 1'b0);
        safeTorqueOffInput <= 1'b1;
        stopReq <= 1'b0;
        recover();
        // short ramp ends in the brake; only ramp start is unmasked
        bus(1'b1, 5'h10, 32'h0000000f);
        bus(1'b1, 5'h14, 32'h00000001);
        bus(1'b1, 5'h08, 32'h00000001);
        speedCmdIn <= 16'h03e8;
        stopReq <= 1'b1;
        settle();
        check_flag(irq, 1'b1);
        bus(1'b1, 5'h10, 32'h00000001);
        settle();
        check_flag(irq, 1'b0);
        wait_power(1'b0, 60000);
        check_flag(dynamicBrakeOn, 1'b1);
        check_flag(zeroSpeedDetect, 1'b1);
        check_word(speedCmdOut, 16'h0000);
        rdchk(5'h10, 32'h00000002);
        rdchk(5'h0c, 32'h00000036);
        stopReq <= 1'b0;
        recover();
        bus(1'b1, 5'h08, 32'h00000064);
        // each same-clock request starts the ramp; a braking alarm then cuts it short
        for (int k = 0; k < 4; k++) begin
            {alarmRampable, commLost, emergencyStopCmd, quickStopCmd} <= 4'b0001 << k;
            settle();
            check_word({4'h0, warningCode}, 16'h00e6);
            alarmDynBrake <= 1'b1;
            settle();
            check_flag(dynamicBrakeOn, 1'b1);
            {alarmRampable, commLost, emergencyStopCmd, quickStopCmd} <= 4'b0000;
            alarmDynBrake <= 1'b0;
            recover();
        end
        // torque mode stop and a non-rampable alarm both brake with no ramp
        for (int k = 0; k < 2; k++) begin
            torqueMode <= (k == 0);
            quickStopCmd <= (k == 0);
            alarmDynBrake <= (k == 1);
            settle();
            check_flag(dynamicBrakeOn, 1'b1);
            check_word({4'h0, warningCode}, 16'h0000);
            {torqueMode, quickStopCmd, alarmDynBrake} <= 3'b000;
            recover();
        end
        // function off: first input governs, alarms brake directly, odd select refused
        bus(1'b1, 5'h00, 32'h0bb80000);
        rdchk(5'h00, 32'h0bb80000);
        alarmRampable <= 1'b1;
        settle();
        check_flag(dynamicBrakeOn, 1'b1);
        check_word({4'h0, warningCode}, 16'h0000);
        alarmRampable <= 1'b0;
        recover();
        forcedStopIn1 <= 1'b0;
        settle();
        check_flag(dynamicBrakeOn, 1'b1);
        forcedStopIn1 <= 1'b1;
        recover();
        bus(1'b1, 5'h10, 32'h0000000f);
        bus(1'b1, 5'h00, 32'h0bb80001);
        rdchk(5'h00, 32'h0bb80000);
        rdchk(5'h10, 32'h00000008);
        completeRun();
    end
endmodule

// File: fsd_pkg.sv
// package for the forced stop deceleration sequencer: register map, resets, timing.
// assumes a single 125 MHz clock and an avalon-mm slave with 32-bit data.
package fsd_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] OFF_CTRL   = 4'h0;  // function select, rated speed
    localparam logic [3:0] OFF_ZERO   = 4'h4;  // zero speed level
    localparam logic [3:0] OFF_DECEL  = 4'h8;  // decel time in ms
    localparam logic [3:0] OFF_STATUS = 4'hc;  // live state, read only
    localparam logic [4:0] OFF_ISTAT  = 5'h10; // sticky events, write one clears
    localparam logic [4:0] OFF_IMASK  = 5'h14; // interrupt mask

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int         SEL_LSB       = 0;
    localparam int         SEL_W         = 4;
    localparam int         RATED_LSB     = 16;
    localparam logic [3:0] SEL_DISABLED  = 4'h0;
    localparam logic [3:0] SEL_ENABLED   = 4'h2;
    localparam logic [3:0] SEL_RST       = 4'h2;
    localparam logic [15:0] ZERO_RST     = 16'h0032;  // 50 speed units
    localparam logic [15:0] DECEL_MS_RST = 16'h0064;  // 100 ms
    localparam logic [15:0] RATED_RST    = 16'h0bb8;  // plain default rated speed
    localparam logic [11:0] WARN_CODE    = 12'h0e6;   // servo forced-stop warning
    localparam int          EVT_W        = 4;         // start, done, abort, illegal sel

    // ------------------------------------------------------------
    // timing: one control tick every 10 us
    // ------------------------------------------------------------
    // a fine tick keeps the ramp smooth at the cost of a wider step divisor
    localparam int CLK_HZ       = 125000000;
    localparam int TICK_US      = 10;
    localparam int TICK_CYCLES  = CLK_HZ / 1000000 * TICK_US;
    localparam int TICKS_PER_MS = 1000 / TICK_US;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_RAMP,
        ST_BRAKE
    } state_type;

endpackage
